// ---- hdl/mpu_pkg.sv ----
// constants, types and layouts shared by the memory protection block
package mpu_pkg;

	localparam int NUM_CORES = 3;
	localparam logic [1:0] ID_OTHER = 2'h3;

	// address map
	localparam logic [7:0] LOCAL_TOP = 8'h00;
	localparam logic [3:0] GLOBAL_NIB = 4'h1;
	localparam logic [11:0] CC_TOP = 12'h02a;
	localparam logic [2:0] LVL2_SEL = 3'h4;
	localparam logic [8:0] PROG1_SEL = 9'h1c0;
	localparam logic [8:0] DATA1_SEL = 9'h1e0;

	// page geometry
	localparam int L1_PAGE_LSB = 11;
	localparam int LVL2_PAGE_LSB = 15;
	localparam int CC_REGION_LSB = 12;

	// permission table layout
	localparam int PAGES_PER_CORE = 96;
	localparam logic [8:0] PROG1_BASE = 9'h000;
	localparam logic [8:0] DATA1_BASE = 9'h010;
	localparam logic [8:0] LVL2_BASE = 9'h020;
	localparam logic [8:0] CC_BASE = 9'h120;
	localparam logic [8:0] CORE_STRIDE = 9'h060;
	localparam int NUM_PERM = 296;
	localparam logic [9:0] PERM_LIMIT = 10'h128;

	// permission word fields
	localparam int P_UR = 0;
	localparam int P_UW = 1;
	localparam int P_UX = 2;
	localparam int P_SR = 3;
	localparam int P_SW = 4;
	localparam int P_SX = 5;
	localparam int P_LOCAL = 6;
	localparam int P_ID_LSB = 7;
	localparam int PERM_W = 11;
	localparam logic [PERM_W-1:0] PERM_RESET = 11'h7ff;

	// register indices (word addresses)
	localparam logic [9:0] CTRL_IDX = 10'h200;
	localparam logic [9:0] FAULT_ADDR_IDX = 10'h201;
	localparam logic [9:0] FAULT_INFO_IDX = 10'h202;
	localparam logic [9:0] FAULT_CNT_IDX = 10'h203;

	// control fields
	localparam int C_EN = 0;
	localparam int C_LOCK = 1;
	localparam int C_EXC_LSB = 2;
	localparam logic [4:0] CTRL_RESET = 5'h1d;

	// fault info fields
	localparam int F_VALID = 0;
	localparam int F_CODE_LSB = 1;
	localparam int F_ID_LSB = 4;
	localparam int F_KIND_LSB = 6;
	localparam int F_SUP = 8;
	localparam int F_DMA = 9;

	typedef enum logic [1:0] {ACC_READ, ACC_WRITE, ACC_EXEC} acc_e;
	typedef enum logic [2:0] {TGT_NONE, TGT_PROG1, TGT_DATA1, TGT_LVL2,
		TGT_CC} tgt_e;
	typedef enum logic [2:0] {FLT_NONE, FLT_UNMAPPED, FLT_LOCAL, FLT_ID,
		FLT_TYPE} flt_e;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		acc_e kind;
		logic sup;
		logic is_dma;
		logic [1:0] src_id;
		logic [1:0] prog_id;
	} req_s;

	typedef struct packed {
		logic we;
		logic exec;
		logic [1:0] core;
		tgt_e tgt;
		logic [20:0] offset;
		logic [31:0] wdata;
	} mem_s;

endpackage : mpu_pkg

// ---- hdl/addr_decode.sv ----
// decodes an access address into target memory, core, page and offset
module addr_decode
	import mpu_pkg::*;
(
	input wire logic [31:0] addr_i,
	input wire logic [1:0] id_i,
	output logic hit_o,
	output logic local_o,
	output logic [1:0] core_o,
	output tgt_e tgt_o,
	output logic [5:0] page_o,
	output logic [20:0] offset_o
);

	logic space_ok;

	always_comb
	begin
		space_ok = 1'b0;
		local_o = 1'b0;
		core_o = 2'h0;
		tgt_o = TGT_NONE;
		page_o = 6'h00;
		offset_o = addr_i[20:0];
		if (addr_i[31:24] == LOCAL_TOP)
		begin
			// a local address names the issuer's own memory only
			local_o = 1'b1;
			core_o = id_i;
			space_ok = (id_i != ID_OTHER);
		end
		else if (addr_i[31:28] == GLOBAL_NIB && addr_i[27:26] == 2'h0)
		begin
			core_o = addr_i[25:24];
			space_ok = (addr_i[25:24] != ID_OTHER);
		end
		if (addr_i[31:20] == CC_TOP && addr_i[19:15] == 5'h00)
		begin
			tgt_o = TGT_CC;
			page_o = {3'h0, addr_i[CC_REGION_LSB+:3]};
		end
		else if (space_ok && addr_i[23:21] == LVL2_SEL)
		begin
			tgt_o = TGT_LVL2;
			page_o = addr_i[LVL2_PAGE_LSB+:6];
		end
		else if (space_ok && addr_i[23:15] == PROG1_SEL)
		begin
			tgt_o = TGT_PROG1;
			page_o = {2'h0, addr_i[L1_PAGE_LSB+:4]};
		end
		else if (space_ok && addr_i[23:15] == DATA1_SEL)
		begin
			tgt_o = TGT_DATA1;
			page_o = {2'h0, addr_i[L1_PAGE_LSB+:4]};
		end
		hit_o = (tgt_o != TGT_NONE);
	end

endmodule : addr_decode

// ---- hdl/mem_protect.sv ----
// per page memory protection in front of the cores' internal memories
//
// Our own choices: the address map and the strobed register port.
module mem_protect
	import mpu_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic req_valid_i,
	input wire req_s req_i,
	input wire logic [9:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic reg_sup_i,
	output logic [31:0] reg_rdata_o,
	output logic mem_valid_o,
	output mem_s mem_o,
	input wire logic mem_rvalid_i,
	input wire logic [31:0] mem_rdata_i,
	output logic resp_valid_o,
	output logic resp_err_o,
	output logic rd_valid_o,
	output logic [31:0] rd_data_o,
	output logic [NUM_CORES-1:0] exc_o
);

	// table slot of a page; cc regions are shared by all cores
	function automatic logic [8:0] perm_index(input tgt_e tgt,
		input logic [1:0] core, input logic [5:0] page);
		logic [8:0] base;
		base = CC_BASE;
		case (tgt)
			TGT_PROG1: base = PROG1_BASE;
			TGT_DATA1: base = DATA1_BASE;
			TGT_LVL2: base = LVL2_BASE;
			default: base = CC_BASE;
		endcase
		if (tgt == TGT_CC)
			perm_index = base + {6'h00, page[2:0]};
		else
			perm_index = base + {3'h0, page} + ({7'h00, core} * CORE_STRIDE);
	endfunction : perm_index

	logic [PERM_W-1:0] perm_r [NUM_PERM];
	logic [PERM_W-1:0] perm_nxt [NUM_PERM];
	logic [4:0] ctrl_r, ctrl_nxt;
	logic [31:0] fault_addr_r, fault_addr_nxt;
	logic [9:0] fault_info_r, fault_info_nxt;
	logic [15:0] fault_cnt_r, fault_cnt_nxt;
	logic [31:0] reg_rdata_r, reg_rdata_nxt;
	logic mem_valid_r, mem_valid_nxt;
	mem_s mem_r, mem_nxt;
	logic resp_valid_r, resp_valid_nxt;
	logic resp_err_r, resp_err_nxt;
	logic rd_valid_r, rd_valid_nxt;
	logic [31:0] rd_data_r, rd_data_nxt;
	logic [NUM_CORES-1:0] exc_r, exc_nxt;

	logic [1:0] eff_id;
	logic dec_hit, dec_local;
	logic [1:0] dec_core;
	tgt_e dec_tgt;
	logic [5:0] dec_page;
	logic [20:0] dec_offset;
	logic [8:0] acc_idx;
	logic [PERM_W-1:0] acc_perm;
	logic type_ok, id_ok, local_ok, allow;
	flt_e flt_code;
	logic cfg_wr, fault_set, fault_clr;

	// a dma transfer is checked as the core that programmed it
	assign eff_id = req_i.is_dma ? req_i.prog_id : req_i.src_id;

	addr_decode u_decode
	(
		.addr_i(req_i.addr),
		.id_i(eff_id),
		.hit_o(dec_hit),
		.local_o(dec_local),
		.core_o(dec_core),
		.tgt_o(dec_tgt),
		.page_o(dec_page),
		.offset_o(dec_offset)
	);

	// permission check
	always_comb
	begin
		acc_idx = perm_index(dec_tgt, dec_core, dec_page);
		acc_perm = perm_r[acc_idx];
		type_ok = 1'b0;
		case (req_i.kind)
			ACC_READ: type_ok = req_i.sup ? acc_perm[P_SR] : acc_perm[P_UR];
			ACC_WRITE: type_ok = req_i.sup ? acc_perm[P_SW] : acc_perm[P_UW];
			ACC_EXEC: type_ok = req_i.sup ? acc_perm[P_SX] : acc_perm[P_UX];
			default: type_ok = 1'b0;
		endcase
		// channel controller registers are never fetched from while checking is enabled (ctrl_r[C_EN] set)
		if (dec_tgt == TGT_CC && req_i.kind == ACC_EXEC)
			type_ok = 1'b0;
		// the id check guards global and region accesses only
		id_ok = dec_local || acc_perm[P_ID_LSB + 32'(eff_id)];
		local_ok = !dec_local || acc_perm[P_LOCAL];
		flt_code = FLT_NONE;
		if (!dec_hit)
			flt_code = FLT_UNMAPPED;
		else if (ctrl_r[C_EN] && !local_ok)
			flt_code = FLT_LOCAL;
		else if (ctrl_r[C_EN] && !id_ok)
			flt_code = FLT_ID;
		else if (ctrl_r[C_EN] && !type_ok)
			flt_code = FLT_TYPE;
		allow = (flt_code == FLT_NONE);
	end

	// access path towards memory
	always_comb
	begin
		mem_nxt.we = (req_i.kind == ACC_WRITE);
		mem_nxt.exec = (req_i.kind == ACC_EXEC);
		mem_nxt.core = dec_core;
		mem_nxt.tgt = dec_tgt;
		mem_nxt.offset = dec_offset;
		mem_nxt.wdata = req_i.wdata;
		mem_valid_nxt = req_valid_i && allow;
		resp_valid_nxt = req_valid_i;
		resp_err_nxt = req_valid_i && !allow;
		// only memory that passed the check ever returns data
		rd_valid_nxt = mem_rvalid_i;
		rd_data_nxt = mem_rvalid_i ? mem_rdata_i : 32'h0000_0000;
		fault_set = req_valid_i && !allow;
		exc_nxt = '0;
		if (fault_set && eff_id != ID_OTHER)
			exc_nxt[eff_id] = ctrl_r[C_EXC_LSB + 32'(eff_id)];
	end

	// register port
	always_comb
	begin
		// user level software may neither read nor change the setup
		cfg_wr = reg_wr_i && reg_sup_i;
		fault_clr = cfg_wr && reg_addr_i == FAULT_INFO_IDX;
		ctrl_nxt = ctrl_r;
		if (cfg_wr && reg_addr_i == CTRL_IDX && !ctrl_r[C_LOCK])
			ctrl_nxt = reg_wdata_i[4:0];
		// a new fault wins over a clear in the same cycle
		fault_info_nxt = fault_info_r;
		fault_addr_nxt = fault_addr_r;
		if (fault_clr)
			fault_info_nxt = '0;
		if (fault_set && (!fault_info_r[F_VALID] || fault_clr))
		begin
			fault_addr_nxt = req_i.addr;
			fault_info_nxt[F_VALID] = 1'b1;
			fault_info_nxt[F_CODE_LSB+:3] = flt_code;
			fault_info_nxt[F_ID_LSB+:2] = eff_id;
			fault_info_nxt[F_KIND_LSB+:2] = req_i.kind;
			fault_info_nxt[F_SUP] = req_i.sup;
			fault_info_nxt[F_DMA] = req_i.is_dma;
		end
		fault_cnt_nxt = fault_cnt_r;
		if (cfg_wr && reg_addr_i == FAULT_CNT_IDX)
			fault_cnt_nxt = 16'h0000;
		if (fault_set && fault_cnt_nxt != 16'hffff)
			fault_cnt_nxt = fault_cnt_nxt + 16'h0001;
		reg_rdata_nxt = 32'h0000_0000;
		if (reg_rd_i && reg_sup_i)
		begin
			if (reg_addr_i < PERM_LIMIT)
				reg_rdata_nxt = {21'h0, perm_r[reg_addr_i[8:0]]};
			else
			begin
				case (reg_addr_i)
					CTRL_IDX: reg_rdata_nxt = {27'h0, ctrl_r};
					FAULT_ADDR_IDX: reg_rdata_nxt = fault_addr_r;
					FAULT_INFO_IDX: reg_rdata_nxt = {22'h0, fault_info_r};
					FAULT_CNT_IDX: reg_rdata_nxt = {16'h0, fault_cnt_r};
					default: reg_rdata_nxt = 32'h0000_0000;
				endcase
			end
		end
	end

	// one flop set per page, written only while the setup is unlocked
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PERM; gi++)
		begin : g_perm
			always_comb
			begin
				perm_nxt[gi] = perm_r[gi];
				if (cfg_wr && !ctrl_r[C_LOCK] && reg_addr_i == 10'(gi))
					perm_nxt[gi] = reg_wdata_i[PERM_W-1:0];
			end

			always_ff @(posedge clk_i)
			begin
				if (!rst_b_i)
					perm_r[gi] <= PERM_RESET;
				else
					perm_r[gi] <= perm_nxt[gi];
			end
		end
	endgenerate

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			ctrl_r <= CTRL_RESET;
			fault_addr_r <= 32'h0000_0000;
			fault_info_r <= 10'h000;
			fault_cnt_r <= 16'h0000;
			reg_rdata_r <= 32'h0000_0000;
			mem_valid_r <= 1'b0;
			mem_r <= '0;
			resp_valid_r <= 1'b0;
			resp_err_r <= 1'b0;
			rd_valid_r <= 1'b0;
			rd_data_r <= 32'h0000_0000;
			exc_r <= '0;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			fault_addr_r <= fault_addr_nxt;
			fault_info_r <= fault_info_nxt;
			fault_cnt_r <= fault_cnt_nxt;
			reg_rdata_r <= reg_rdata_nxt;
			mem_valid_r <= mem_valid_nxt;
			mem_r <= mem_nxt;
			resp_valid_r <= resp_valid_nxt;
			resp_err_r <= resp_err_nxt;
			rd_valid_r <= rd_valid_nxt;
			rd_data_r <= rd_data_nxt;
			exc_r <= exc_nxt;
		end
	end

	assign reg_rdata_o = reg_rdata_r;
	assign mem_valid_o = mem_valid_r;
	assign mem_o = mem_r;
	assign resp_valid_o = resp_valid_r;
	assign resp_err_o = resp_err_r;
	assign rd_valid_o = rd_valid_r;
	assign rd_data_o = rd_data_r;
	assign exc_o = exc_r;

endmodule : mem_protect

// ---- dv/mp_chk_asserts.sv ----
// port assertions for the memory protection block
module mp_chk
	import mpu_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic req_valid_i,
	input wire req_s req_i,
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic mem_valid_o,
	input wire mem_s mem_o,
	input wire logic mem_rvalid_i,
	input wire logic rd_valid_o,
	input wire logic resp_valid_o,
	input wire logic resp_err_o,
	input wire logic [NUM_CORES-1:0] exc_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] eff;
	logic [20:0] off;
	logic loc;
	assign eff = req_i.is_dma ? req_i.prog_id : req_i.src_id;
	assign off = req_i.addr[20:0];
	assign loc = req_valid_i && req_i.addr[31:24] == 8'h00;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	a_resp_once: assert property (req_valid_i |=> resp_valid_o)
		else $error("no response after request");
	a_idle_quiet: assert property (!req_valid_i |=>
		!resp_valid_o && !mem_valid_o && exc_o == '0)
		else $error("output without request");
	a_err_no_mem: assert property (resp_valid_o |->
		mem_valid_o != resp_err_o)
		else $error("forward and reject disagree");
	a_exc_on_err: assert property (exc_o != '0 |->
		resp_err_o && $onehot(exc_o))
		else $error("exception without rejection");
	a_local_other: assert property (loc && eff == 2'h3 |=>
		resp_err_o)
		else $error("local access from other master passed");
	a_local_core: assert property (loc |=>
		!mem_valid_o || mem_o.core == $past(eff))
		else $error("local access routed to wrong core");
	a_offset_keep: assert property (req_valid_i |=>
		mem_o.offset == $past(off))
		else $error("offset not passed through");
	a_write_flag: assert property (req_valid_i &&
		req_i.kind == ACC_WRITE |=> !mem_valid_o || mem_o.we)
		else $error("write forwarded as read");
	a_rd_follow: assert property (mem_rvalid_i |=> rd_valid_o)
		else $error("read data not returned");
	a_reg_quiet: assert property (!reg_rd_i |=> reg_rdata_o == '0)
		else $error("read data outside read slot");
endmodule : mp_chk

bind mem_protect mp_chk chk_i (.clk_i, .rst_b_i, .req_valid_i, .req_i,
	.reg_rd_i, .reg_rdata_o, .mem_valid_o, .mem_o, .mem_rvalid_i,
	.rd_valid_o, .resp_valid_o, .resp_err_o, .exc_o);

// ---- dv/mem_model.sv ----
// behavioural memory answering forwarded reads one cycle later
module mem_model
	import mpu_pkg::*;
(
	input wire logic clk_i,
	input wire logic mem_valid_i,
	input wire mem_s mem_i,
	output logic rvalid_o,
	output logic [31:0] rdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial rvalid_o = 1'b0;
	initial rdata_o = 32'h0;
	// idle data toggles so a stale word never passes for a valid one
	always @(posedge clk_i)
	begin
		rvalid_o <= mem_valid_i && !mem_i.we;
		rdata_o <= (mem_valid_i && !mem_i.we) ?
			{3'(mem_i.tgt), mem_i.core, 6'h0, mem_i.offset} : ~rdata_o;
	end
endmodule : mem_model

// ---- dv/tb_top.sv ----
// random accesses checked against a reference permission table
module tb_top
	import mpu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_b, req_v, wr, rd, sup, mrv, mv, rsp_v, err, rdv;
	req_s req;
	mem_s mo;
	logic [9:0] ra;
	logic [31:0] wd, rdat, mrd, rdd;
	logic [2:0] exc;
	logic [10:0] perm [0:NUM_PERM-1];
	int bad_count, checks, nflt;
	logic [4:0] ctl;
	mem_protect uut (.clk_i(clk), .rst_b_i(rst_b), .req_valid_i(req_v),
		.req_i(req), .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_sup_i(sup), .reg_rdata_o(rdat),
		.mem_valid_o(mv), .mem_o(mo), .mem_rvalid_i(mrv),
		.mem_rdata_i(mrd), .resp_valid_o(rsp_v), .resp_err_o(err),
		.rd_valid_o(rdv), .rd_data_o(rdd), .exc_o(exc));
	mem_model mem (.clk_i(clk), .mem_valid_i(mv), .mem_i(mo),
		.rvalid_o(mrv), .rdata_o(mrd));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic end_sim();
		$display("checks=%0d mismatches=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	task automatic reg_wr(input logic [9:0] a, input logic [31:0] d);
		@(posedge clk);
		ra <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : reg_wr
	task automatic reg_rd(input logic [9:0] a, input logic [31:0] e);
		@(posedge clk);
		ra <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdat, e);
	endtask : reg_rd
	function automatic void ref_chk(input req_s r, output logic e,
		output tgt_e t, output logic [1:0] c);
		logic [1:0] id;
		logic loc, hit;
		logic [9:0] i;
		logic [10:0] p;
		id = r.is_dma ? r.prog_id : r.src_id;
		loc = r.addr[31:24] == 8'h00;
		c = loc ? id : r.addr[25:24];
		hit = c != 2'h3 && (loc || r.addr[31:26] == 6'h04);
		t = TGT_NONE;
		i = 10'(c) * 10'h060;
		if (r.addr[31:15] == 17'h00540)
			hit = 1'b1;
		if (r.addr[31:15] == 17'h00540)
			t = TGT_CC;
		else if (r.addr[23:21] == 3'h4)
			t = TGT_LVL2;
		else if (r.addr[23:15] == 9'h1c0)
			t = TGT_PROG1;
		else if (r.addr[23:15] == 9'h1e0)
			t = TGT_DATA1;
		else
			hit = 1'b0;
		if (t == TGT_CC)
			i = 10'h120 + 10'(r.addr[14:12]);
		else if (t == TGT_LVL2)
			i += 10'h020 + 10'(r.addr[20:15]);
		else
			i += (t == TGT_DATA1 ? 10'h010 : 10'h000) + 10'(r.addr[14:11]);
		p = hit ? perm[i] : 11'h0;
		// with checking off only unmapped addresses are refused
		e = !hit || (ctl[0] && ((loc ? !p[6] : !p[7 + id]) ||
			!p[(r.sup ? 3 : 0) + r.kind] ||
			(t == TGT_CC && r.kind == ACC_EXEC)));
	endfunction : ref_chk
	task automatic acc(input req_s r);
		logic e;
		logic [2:0] xe;
		logic [1:0] id, c;
		tgt_e t;
		ref_chk(r, e, t, c);
		id = r.is_dma ? r.prog_id : r.src_id;
		@(posedge clk);
		req <= r;
		req_v <= 1'b1;
		@(posedge clk);
		req_v <= 1'b0;
		#1 chk(err, e);
		chk(rsp_v, 1'b1);
		chk(mv, !e);
		xe = (e && id != 2'h3 && ctl[2 + id]) ? 3'(1 << id) : 3'h0;
		chk(exc, xe);
		if (e)
			nflt++;
		if (!e && t != TGT_CC)
		begin
			chk({mo.core, mo.tgt}, {c, t});
			chk(mo.offset, r.addr[20:0]);
		end
		if (!e && t != TGT_CC && r.kind != ACC_WRITE)
		begin
			repeat (2) @(posedge clk);
			#1 chk(rdd, {3'(t), c, 6'h0, r.addr[20:0]});
			chk(rdv, 1'b1);
		end
	endtask : acc
	function automatic req_s rnd_req();
		req_s r;
		logic [23:0] s;
		r.wdata = $urandom;
		r.kind = acc_e'($urandom % 3);
		r.sup = 1'($urandom);
		r.is_dma = 1'($urandom);
		r.src_id = 2'($urandom);
		r.prog_id = 2'($urandom % 3);
		case ($urandom % 3)
			0: s = {3'h4, 21'($urandom)};
			1: s = {9'h1c0, 15'($urandom)};
			default: s = {9'h1e0, 15'($urandom)};
		endcase
		case ($urandom % 4)
			0: r.addr = {8'h00, s};
			1: r.addr = {6'h04, 2'($urandom), s};
			2: r.addr = {17'h00540, 15'($urandom)};
			default: r.addr = $urandom;
		endcase
		return r;
	endfunction : rnd_req
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial
	begin
		repeat (90000) @(posedge clk);
		bad_count++;
		end_sim();
	end
	initial
	begin
		req_s r;
		logic [9:0] i;
		logic [31:0] v;
		rst_b = 1'b0;
		req_v = 1'b0;
		req = '0;
		ra = 10'h0;
		wd = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		sup = 1'b1;
		ctl = CTRL_RESET;
		nflt = 0;
		void'($urandom(19317));
		foreach (perm[k])
			perm[k] = PERM_RESET;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		reg_rd(CTRL_IDX, 32'h1d);
		reg_rd(10'h300, 32'h0);
		sup <= 1'b0;
		reg_wr(10'h000, 32'h0);
		sup <= 1'b1;
		reg_rd(10'h000, 32'h7ff);
		$display("reset and register access done");
		for (int n = 0; n < 400; n++)
		begin
			if ($urandom % 6 == 0)
			begin
				i = 10'($urandom % NUM_PERM);
				v = $urandom;
				perm[i] = v[10:0];
				reg_wr(i, v);
				reg_rd(i, {21'h0, perm[i]});
			end
			acc(rnd_req());
		end
		$display("random accesses done");
		reg_wr(FAULT_INFO_IDX, 32'h0);
		r = '0;
		r.addr = 32'h0300_0000;
		acc(r);
		reg_rd(FAULT_INFO_IDX, 32'h3);
		reg_rd(FAULT_ADDR_IDX, 32'h0300_0000);
		reg_rd(FAULT_CNT_IDX, 32'(nflt));
		// a clear and a fault in one cycle: the fault must stick
		fork
			reg_wr(FAULT_CNT_IDX, 32'h0);
			acc(r);
		join
		r.src_id = 2'h1;
		fork
			reg_wr(FAULT_INFO_IDX, 32'h0);
			acc(r);
		join
		reg_rd(FAULT_CNT_IDX, 32'h2);
		reg_rd(FAULT_INFO_IDX, 32'h13);
		$display("fault log done");
		// checking off, only core 0 may be told of a fault
		ctl = 5'h04;
		reg_wr(CTRL_IDX, 32'h04);
		for (int n = 0; n < 40; n++)
			acc(rnd_req());
		$display("checking off done");
		ctl = 5'h1f;
		reg_wr(CTRL_IDX, 32'h1f);
		reg_wr(CTRL_IDX, 32'h0);
		reg_rd(CTRL_IDX, 32'h1f);
		reg_wr(10'h005, 32'h0);
		reg_rd(10'h005, {21'h0, perm[5]});
		$display("lock done");
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		reg_rd(CTRL_IDX, {27'h0, CTRL_RESET});
		reg_rd(10'h005, {21'h0, PERM_RESET});
		$display("second reset done");
		end_sim();
	end
endmodule : tb_top
